/* File: verilog/ssp_regs.svh */
// Register offsets, field positions, reset values and counts of the serial port.
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH
`define SSP_OFS_RCSTA  8'h00
`define SSP_OFS_RXBUF  8'h04
`define SSP_OFS_TXSTA  8'h08
`define SSP_OFS_BAUD   8'h0c
`define SSP_OFS_DIVH   8'h10
`define SSP_OFS_DIVL   8'h14
`define SSP_OFS_TXBUF  8'h18
`define SSP_OFS_FLAGS  8'h1c
`define SSP_RC_SERIAL_PORT_ENABLE    7
`define SSP_RC_RX9     6
`define SSP_RC_SINGLE_RECEIVE_ENABLE    5
`define SSP_RC_CONTINUOUS_RECEIVE_ENABLE    4
`define SSP_RC_OVERRUN_ERROR_FLAG    1
`define SSP_RC_RECEIVED_NINTH_BIT    0
`define SSP_TX_CLOCK_SOURCE_SELECT    7
`define SSP_TX_TX9     6
`define SSP_TX_TRANSMIT_ENABLE_BIT    5
`define SSP_TX_SYNC    4
`define SSP_TX_SHIFTER_EMPTY_FLAG    1
`define SSP_TX_TRANSMIT_NINTH_BIT    0
`define SSP_BD_CLOCK_IDLE_POLARITY    4
`define SSP_BD_WIDE    3
`define SSP_FL_RCIE    0
`define SSP_FL_TXIE    1
`define SSP_FL_RCIF    4
`define SSP_FL_TXIF    5
`define SSP_RCSTA_WMASK 8'hf0
`define SSP_TXSTA_WMASK 8'hf1
`define SSP_BAUD_WMASK  8'h18
`define SSP_FLAGS_WMASK 8'h03
`define SSP_BYTE_RST   8'h00
`define SSP_DIV_RST    16'h0000
`define SSP_CNT_ZERO   4'h0
`define SSP_BITS_8     4'h8
`define SSP_BITS_9     4'h9
`define SSP_RESP_OKAY  2'h0
`define SSP_RESP_SLV   2'h2
`endif

/* File: verilog/ssp_pkg.sv */
// Types shared by the serial port design files.
package ssp_pkg;
   // Transmit shifter state: empty or shifting a word out.
   typedef enum logic {TXS_EMPTY, TXS_SHIFT} ssp_tx_st_t;
   // Width of the divider count.
   typedef logic [15:0] ssp_div_t;
endpackage : ssp_pkg

/* File: verilog/ssp_rate_gen.sv */
// Shift clock rate generator producing one tick per divisor period.
`include "ssp_regs.svh"
module ssp_rate_gen
   import ssp_pkg::*;
(
   input  wire logic       aclk,    // System clock.
   input  wire logic       aresetn, // Synchronous reset, active low.
   input  wire logic       ce,      // Clock enable.
   input  wire logic       run,     // Count while high.
   input  wire logic       wide,    // Use the full 16-bit divisor.
   input  wire logic [7:0] div_hi,  // High divisor byte.
   input  wire logic [7:0] div_lo,  // Low divisor byte.
   output logic            tick     // One-cycle tick at the half period.
);
   ssp_div_t cnt_q;   // Down counter.
   ssp_div_t cnt_d;   // Next counter value.
   ssp_div_t div;     // Selected divisor.

   // Reload on idle so the first half period after start is a full one.
   always_comb begin
      div   = wide ? {div_hi, div_lo} : {8'h00, div_lo};
      cnt_d = cnt_q;
      tick  = 1'b0;
      if (!run) begin
         cnt_d = div;
      end else if (cnt_q == `SSP_DIV_RST) begin
         cnt_d = div;
         tick  = 1'b1;
      end else begin
         cnt_d = cnt_q - 16'h0001;
      end
   end

   // Counter register, frozen while the clock enable is low.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= `SSP_DIV_RST;
      end else if (ce) begin
         cnt_q <= cnt_d;
      end
   end
endmodule : ssp_rate_gen

/* File: verilog/ssp_top.sv */
// Synchronous serial port: master and slave reception, slave transmission, AXI4-Lite registers.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`include "ssp_regs.svh"
module ssp_top
   import ssp_pkg::*;
(
   input  wire logic        aclk,      // System clock, 20 MHz.
   input  wire logic        aresetn,   // Synchronous reset, active low.
   input  wire logic        ce,        // Clock enable, freezes all state when low.
   input  wire logic [7:0]  awaddr,    // Write address.
   input  wire logic        awvalid,   // Write address valid.
   output logic             awready,   // Write address ready.
   input  wire logic [31:0] wdata,     // Write data.
   input  wire logic [3:0]  wstrb,     // Write byte strobes.
   input  wire logic        wvalid,    // Write data valid.
   output logic             wready,    // Write data ready.
   output logic [1:0]       bresp,     // Write response.
   output logic             bvalid,    // Write response valid.
   input  wire logic        bready,    // Write response ready.
   input  wire logic [7:0]  araddr,    // Read address.
   input  wire logic        arvalid,   // Read address valid.
   output logic             arready,   // Read address ready.
   output logic [31:0]      rdata,     // Read data.
   output logic [1:0]       rresp,     // Read response.
   output logic             rvalid,    // Read data valid.
   input  wire logic        rready,    // Read data ready.
   input  wire logic        ck_in,     // Shift clock pin level.
   output logic             ck_out,    // Shift clock pin drive value.
   output logic             ck_oe_n,   // Shift clock pin drive enable, low drives.
   input  wire logic        dt_in,     // Serial data pin level.
   output logic             dt_out,    // Serial data pin drive value.
   output logic             dt_oe_n,   // Serial data pin drive enable, low drives.
   input  wire logic        low_power, // Chip is in a low-power mode.
   output logic             irq,       // Interrupt request, level.
   output logic             wake       // Wake request during low power, level.
);
   // Bus side state.
   logic        aw_have_q, aw_have_d;   // Write address held.
   logic [7:0]  awa_q, awa_d;           // Held write address.
   logic        w_have_q, w_have_d;     // Write data held.
   logic [7:0]  wd_q, wd_d;             // Held low write byte.
   logic        wlane_q, wlane_d;       // Low byte lane strobe.
   logic        bvalid_q, bvalid_d;     // Response pending.
   logic [1:0]  bresp_q, bresp_d;       // Write response code.
   logic        awrdy_q, awrdy_d;       // Registered ready outputs.
   logic        wrdy_q, wrdy_d;
   logic        arrdy_q, arrdy_d;
   logic        rvalid_q, rvalid_d;     // Read data pending.
   logic [31:0] rdata_q, rdata_d;       // Read data.
   logic [1:0]  rresp_q, rresp_d;       // Read response code.
   logic        wr_fire, rd_fire;       // Register write and read this cycle.
   // Core state.
   logic [7:0]  rcsta_q, rcsta_d;       // Receive status and control.
   logic [7:0]  rxbuf_q, rxbuf_d;       // Receive buffer.
   logic [7:0]  txsta_q, txsta_d;       // Transmit status and control.
   logic [7:0]  baud_q, baud_d;         // Baud control.
   logic [7:0]  divh_q, divh_d;         // Divisor high byte.
   logic [7:0]  divl_q, divl_d;         // Divisor low byte.
   logic [7:0]  txbuf_q, txbuf_d;       // Transmit buffer.
   logic [1:0]  ie_q, ie_d;             // Receive and transmit interrupt enables.
   logic        rcif_q, rcif_d;         // Receive flag.
   logic        txif_q, txif_d;         // Transmit flag, high when buffer empty.
   logic [8:0]  rsr_q, rsr_d;           // Receive shift register.
   logic [3:0]  rcnt_q, rcnt_d;         // Received bit count.
   logic [8:0]  tsr_q, tsr_d;           // Transmit shifter.
   logic [3:0]  tcnt_q, tcnt_d;         // Bits left in shifter.
   ssp_tx_st_t  tst_q, tst_d;           // Shifter state.
   logic        ph_q, ph_d;             // Master clock phase, high mid-bit.
   logic        ck_m_q, ck_s_q, ck_p_q; // Clock pin synchroniser and history.
   logic        dt_m_q, dt_s_q;         // Data pin synchroniser.
   logic        ck_out_q, ck_oe_n_q, dt_out_q, dt_oe_n_q, irq_q, wake_q;
   logic        master, slave, rx_act, tx_ok, tick, samp, s_fall, rx_done, tx_load;

   // Bit count of a word for the selected width.
   function automatic logic [3:0] f_bits(input logic nine);
      f_bits = nine ? `SSP_BITS_9 : `SSP_BITS_8;
   endfunction : f_bits

   // True when the byte address names a register.
   function automatic logic f_hit(input logic [7:0] a);
      f_hit = (a[1:0] == 2'b00) && (a <= `SSP_OFS_FLAGS);
   endfunction : f_hit

   // Read multiplexer; reserved and unimplemented bits read as zero.
   function automatic logic [7:0] f_rd(input logic [7:0] a);
      case (a)
         `SSP_OFS_RCSTA: f_rd = rcsta_q;
         `SSP_OFS_RXBUF: f_rd = rxbuf_q;
         `SSP_OFS_TXSTA: f_rd = txsta_q | {6'h00, tst_q == TXS_EMPTY, 1'b0};
         `SSP_OFS_BAUD:  f_rd = baud_q;
         `SSP_OFS_DIVH:  f_rd = divh_q;
         `SSP_OFS_DIVL:  f_rd = divl_q;
         `SSP_OFS_TXBUF: f_rd = txbuf_q;
         `SSP_OFS_FLAGS: f_rd = {2'b00, txif_q, rcif_q, 2'b00, ie_q};
         default:        f_rd = `SSP_BYTE_RST;
      endcase
   endfunction : f_rd

   // Mode decode; the clock source bit picks master or slave.
   assign master = rcsta_q[`SSP_RC_SERIAL_PORT_ENABLE] & txsta_q[`SSP_TX_SYNC] & txsta_q[`SSP_TX_CLOCK_SOURCE_SELECT];
   assign slave  = rcsta_q[`SSP_RC_SERIAL_PORT_ENABLE] & txsta_q[`SSP_TX_SYNC] & ~txsta_q[`SSP_TX_CLOCK_SOURCE_SELECT];

   // Master rate; runs only while a reception is enabled or a half bit is open.
   ssp_rate_gen u_rate (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .run     (master & (rcsta_q[`SSP_RC_SINGLE_RECEIVE_ENABLE] | rcsta_q[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE] | ph_q)),
      .wide    (baud_q[`SSP_BD_WIDE]),
      .div_hi  (divh_q),
      .div_lo  (divl_q),
      .tick    (tick)
   );

   // AXI4-Lite handshakes: address and data taken in either order.
   always_comb begin
      wr_fire  = aw_have_q & w_have_q & ~bvalid_q;
      rd_fire  = arvalid & arrdy_q;
      aw_have_d = aw_have_q;
      awa_d    = awa_q;
      w_have_d = w_have_q;
      wd_d     = wd_q;
      wlane_d  = wlane_q;
      bvalid_d = bvalid_q;
      bresp_d  = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      if (awvalid && awrdy_q) begin
         aw_have_d = 1'b1;
         awa_d     = awaddr;
      end
      if (wvalid && wrdy_q) begin
         w_have_d = 1'b1;
         wd_d     = wdata[7:0];
         wlane_d  = wstrb[0];
      end
      if (wr_fire) begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = f_hit(awa_q) ? `SSP_RESP_OKAY : `SSP_RESP_SLV;
      end else if (bvalid_q && bready) begin
         bvalid_d = 1'b0;
      end
      if (rd_fire) begin
         rvalid_d = 1'b1;
         rdata_d  = {24'h000000, f_rd(araddr)};
         rresp_d  = f_hit(araddr) ? `SSP_RESP_OKAY : `SSP_RESP_SLV;
      end else if (rvalid_q && rready) begin
         rvalid_d = 1'b0;
      end
      awrdy_d = ~aw_have_d & ~bvalid_d;
      wrdy_d  = ~w_have_d & ~bvalid_d;
      arrdy_d = ~rvalid_d;
   end

   // Bus registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         awa_q     <= `SSP_BYTE_RST;
         w_have_q  <= 1'b0;
         wd_q      <= `SSP_BYTE_RST;
         wlane_q   <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `SSP_RESP_OKAY;
         awrdy_q   <= 1'b0;
         wrdy_q    <= 1'b0;
         arrdy_q   <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= `SSP_RESP_OKAY;
      end else if (ce) begin
         aw_have_q <= aw_have_d;
         awa_q     <= awa_d;
         w_have_q  <= w_have_d;
         wd_q      <= wd_d;
         wlane_q   <= wlane_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         awrdy_q   <= awrdy_d;
         wrdy_q    <= wrdy_d;
         arrdy_q   <= arrdy_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
      end
   end

   // Serial engine and register file. Slave timing comes only from the
   // clock pin, so nothing here waits on the system being awake.
   always_comb begin
      logic wr;
      wr       = wr_fire & wlane_q;
      rcsta_d  = rcsta_q;
      rxbuf_d  = rxbuf_q;
      txsta_d  = txsta_q;
      baud_d   = baud_q;
      divh_d   = divh_q;
      divl_d   = divl_q;
      txbuf_d  = txbuf_q;
      ie_d     = ie_q;
      rcif_d   = rcif_q;
      txif_d   = txif_q;
      rsr_d    = rsr_q;
      rcnt_d   = rcnt_q;
      tsr_d    = tsr_q;
      tcnt_d   = tcnt_q;
      tst_d    = tst_q;
      ph_d     = ph_q;
      rx_done  = 1'b0;
      tx_load  = 1'b0;
      // Falling edge of the external clock, normalised by the idle polarity.
      s_fall   = (ck_p_q ^ baud_q[`SSP_BD_CLOCK_IDLE_POLARITY]) & ~(ck_s_q ^ baud_q[`SSP_BD_CLOCK_IDLE_POLARITY]);
      // Single enable is ignored in slave mode.
      rx_act   = master ? (rcsta_q[`SSP_RC_SINGLE_RECEIVE_ENABLE] | rcsta_q[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE])
                        : (slave & rcsta_q[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE]);
      // Half duplex: transmission only in slave mode with reception off.
      tx_ok    = slave & txsta_q[`SSP_TX_TRANSMIT_ENABLE_BIT] & ~rx_act;
      if (master && tick) begin
         ph_d = ~ph_q;
      end
      samp = master ? (tick & ph_q) : (slave & s_fall);
      // Receive shifting, least significant bit first.
      if (!rx_act) begin
         rcnt_d = `SSP_CNT_ZERO;
      end else if (samp) begin
         rsr_d  = {dt_s_q, rsr_q[8:1]};
         rcnt_d = rcnt_q + 4'h1;
         if (rcnt_d == f_bits(rcsta_q[`SSP_RC_RX9])) begin
            rx_done = 1'b1;
            rcnt_d  = `SSP_CNT_ZERO;
         end
      end
      // Software writes; hardware events below take precedence.
      if (wr) begin
         case (awa_q)
            `SSP_OFS_RCSTA: begin
               rcsta_d = (rcsta_q & ~`SSP_RCSTA_WMASK) | (wd_q & `SSP_RCSTA_WMASK);
               if (!wd_q[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE]) begin
                  rcsta_d[`SSP_RC_OVERRUN_ERROR_FLAG] = 1'b0;
               end
            end
            `SSP_OFS_TXSTA: txsta_d = wd_q & `SSP_TXSTA_WMASK;
            `SSP_OFS_BAUD:  baud_d  = wd_q & `SSP_BAUD_WMASK;
            `SSP_OFS_DIVH:  divh_d  = wd_q;
            `SSP_OFS_DIVL:  divl_d  = wd_q;
            `SSP_OFS_TXBUF: begin
               txbuf_d = wd_q;
               txif_d  = 1'b0;
            end
            `SSP_OFS_FLAGS: ie_d = wd_q[1:0];
            default: ;
         endcase
      end
      if (rd_fire && araddr == `SSP_OFS_RXBUF) begin
         rcif_d = 1'b0;
      end
      // Word complete: deliver it, or flag overrun and drop it.
      if (rx_done) begin
         if (rcif_q && rcsta_q[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE]) begin
            rcsta_d[`SSP_RC_OVERRUN_ERROR_FLAG] = 1'b1;
         end else begin
            rxbuf_d = rcsta_q[`SSP_RC_RX9] ? rsr_d[7:0] : rsr_d[8:1];
            // Eight-bit words leave data bit seven in the top stage; keep it out of the field.
            rcsta_d[`SSP_RC_RECEIVED_NINTH_BIT] = rcsta_q[`SSP_RC_RX9] & rsr_d[8];
            rcif_d  = 1'b1;
         end
         if (!rcsta_q[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE]) begin
            rcsta_d[`SSP_RC_SINGLE_RECEIVE_ENABLE] = 1'b0;
         end
      end
      // Transmit shifter, shifting on each falling edge from the peer.
      case (tst_q)
         TXS_EMPTY: begin
            if (tx_ok && !txif_q) begin
               tsr_d   = {txsta_q[`SSP_TX_TRANSMIT_NINTH_BIT], txbuf_q};
               tcnt_d  = f_bits(txsta_q[`SSP_TX_TX9]);
               tst_d   = TXS_SHIFT;
               txif_d  = 1'b1;
               tx_load = 1'b1;
            end
         end
         TXS_SHIFT: begin
            if (!tx_ok) begin
               tst_d = TXS_EMPTY;
            end else if (s_fall) begin
               tsr_d  = {1'b0, tsr_q[8:1]};
               tcnt_d = tcnt_q - 4'h1;
               if (tcnt_d == `SSP_CNT_ZERO) begin
                  tst_d = TXS_EMPTY;
               end
            end
         end
         default: tst_d = TXS_EMPTY;
      endcase
   end

   // Core registers and pin stages; the first synchroniser stage feeds only the second.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rcsta_q   <= `SSP_BYTE_RST;
         rxbuf_q   <= `SSP_BYTE_RST;
         txsta_q   <= `SSP_BYTE_RST;
         baud_q    <= `SSP_BYTE_RST;
         divh_q    <= `SSP_BYTE_RST;
         divl_q    <= `SSP_BYTE_RST;
         txbuf_q   <= `SSP_BYTE_RST;
         ie_q      <= 2'b00;
         rcif_q    <= 1'b0;
         txif_q    <= 1'b1;
         rsr_q     <= 9'h000;
         rcnt_q    <= `SSP_CNT_ZERO;
         tsr_q     <= 9'h000;
         tcnt_q    <= `SSP_CNT_ZERO;
         tst_q     <= TXS_EMPTY;
         ph_q      <= 1'b0;
         {ck_m_q, ck_s_q, ck_p_q, dt_m_q, dt_s_q} <= 5'h00;
         {ck_out_q, dt_out_q, irq_q, wake_q}      <= 4'h0;
         {ck_oe_n_q, dt_oe_n_q}                   <= 2'h3;
      end else if (ce) begin
         rcsta_q   <= rcsta_d;
         rxbuf_q   <= rxbuf_d;
         txsta_q   <= txsta_d;
         baud_q    <= baud_d;
         divh_q    <= divh_d;
         divl_q    <= divl_d;
         txbuf_q   <= txbuf_d;
         ie_q      <= ie_d;
         rcif_q    <= rcif_d;
         txif_q    <= txif_d;
         rsr_q     <= rsr_d;
         rcnt_q    <= rcnt_d;
         tsr_q     <= tsr_d;
         tcnt_q    <= tcnt_d;
         tst_q     <= tst_d;
         ph_q      <= ph_d;
         ck_m_q    <= ck_in;
         ck_s_q    <= ck_m_q;
         ck_p_q    <= ck_s_q;
         dt_m_q    <= dt_in;
         dt_s_q    <= dt_m_q;
         ck_out_q  <= ph_d ^ baud_d[`SSP_BD_CLOCK_IDLE_POLARITY];
         ck_oe_n_q <= ~(master);
         dt_out_q  <= tsr_d[0];
         dt_oe_n_q <= ~(tst_d == TXS_SHIFT);
         irq_q     <= (rcif_d & ie_d[`SSP_FL_RCIE]) | (txif_d & ie_d[`SSP_FL_TXIE]);
         wake_q    <= low_power & slave & txif_d & ie_d[`SSP_FL_TXIE];
      end
   end

   assign {awready, wready, arready} = {awrdy_q, wrdy_q, arrdy_q};
   assign {bvalid, bresp, rvalid, rdata, rresp} = {bvalid_q, bresp_q, rvalid_q, rdata_q, rresp_q};
   assign {ck_out, ck_oe_n, dt_out, dt_oe_n} = {ck_out_q, ck_oe_n_q, dt_out_q, dt_oe_n_q};
   assign {irq, wake} = {irq_q, wake_q};

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_word_ok; rx_done && !(rcif_q && rcsta_q[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE]); endsequence
   sequence s_flag_up; rcif_q && $changed(rcsta_q) || rcif_q; endsequence
   sequence s_loaded;  txif_q && tst_q == TXS_SHIFT; endsequence

   a_word_flag: assert property (s_word_ok |=> s_flag_up)
      else $error("receive flag not set after word");
   a_single_stop: assert property (
         rx_done && !rcsta_q[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE] |=> !rcsta_q[`SSP_RC_SINGLE_RECEIVE_ENABLE])
      else $error("single enable not cleared");
   // A software write in the completing cycle may legally change the enables.
   a_cont_keeps: assert property (
         rx_done && rcsta_q[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE] && !(wr_fire && awa_q == `SSP_OFS_RCSTA)
         |=> rcsta_q[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE] && rcsta_q[`SSP_RC_SINGLE_RECEIVE_ENABLE] == $past(rcsta_q[`SSP_RC_SINGLE_RECEIVE_ENABLE]))
      else $error("continuous reception disturbed");
   a_overrun_set: assert property (
         rx_done && rcif_q && rcsta_q[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE] |=> rcsta_q[`SSP_RC_OVERRUN_ERROR_FLAG] && $stable(rxbuf_q))
      else $error("overrun not flagged or word kept");
   a_err_clear: assert property (
         wr_fire && wlane_q && awa_q == `SSP_OFS_RCSTA && !wd_q[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE] && !rx_done
         |=> !rcsta_q[`SSP_RC_OVERRUN_ERROR_FLAG])
      else $error("error not cleared with continuous enable");
   a_tx_move: assert property (tst_q == TXS_EMPTY && tx_ok && !txif_q && ce |=> s_loaded)
      else $error("buffer not moved to shifter");
   a_txif_hold: assert property (
         tst_q == TXS_SHIFT && !txif_q && !(wr_fire && awa_q == `SSP_OFS_TXBUF)
         |=> !txif_q || tx_load)
      else $error("transmit flag set without a move");
   // With no reception and no open half bit the divider is held, so the pin must idle.
   a_clk_idle: assert property (
         master && !rx_act && !ph_q |=> ck_out == baud_q[`SSP_BD_CLOCK_IDLE_POLARITY])
      else $error("shift clock not idle");
   // The request is registered from the same next values as the flags and enables.
   a_irq_gate: assert property (
         irq == (rcif_q && ie_q[`SSP_FL_RCIE] || txif_q && ie_q[`SSP_FL_TXIE]))
      else $error("request does not follow enabled flags");
endmodule : ssp_top

/* File: dv/ssp_peer.sv */
// Behavioural serial peer on the shift clock and data wires.
module ssp_peer (
   input  wire logic ck_w, // Shift clock wire level.
   input  wire logic dt_w, // Data wire level.
   output logic      p_ck, // Clock the peer drives in slave mode.
   output logic      p_dt  // Data the peer drives toward the port.
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      p_ck = 1'b0;
      p_dt = 1'b0;
   end
   // Sends LSB first; bits change only after the port's falling edge.
   task send(input logic [8:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         p_dt = w[i];
         @(negedge ck_w);
      end
      p_dt = ~w[n-1]; // Inverted last bit: never leave a stale level.
   endtask : send
   // Clocks bits out at 400 ns, still between frames.
   task clock_in(input int n, output logic [8:0] w);
      w = 9'h000;
      for (int i = 0; i < n; i++) begin
         #200;
         p_ck = 1'b1;
         #190;
         w[i] = dt_w;
         #10;
         p_ck = 1'b0;
      end
   endtask : clock_in
endmodule : ssp_peer

/* File: dv/ssp_top_tb.sv */
// Self-checking bench: register bus, master receive, slave send.
`include "ssp_regs.svh"
module ssp_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, low_power = 0, p_ck, p_dt, ck_in, dt_in;
   logic awready, wready, bvalid, arready, rvalid, ck_out, ck_oe_n;
   logic dt_out, dt_oe_n, irq, wake;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0]  wstrb = 4'hf;
   logic [1:0]  bresp, rresp;
   logic [8:0]  w0, w1, got;
   logic [65:0] expq[$]; // Pending reads: mask, response, data.
   int failures = 0;
   int n_tests = 0;
   assign ck_in = ck_oe_n ? p_ck : ck_out;
   assign dt_in = dt_oe_n ? p_dt : dt_out;
   ssp_top uut (.*);
   ssp_peer peer (.ck_w(ck_in), .dt_w(dt_in), .p_ck(p_ck), .p_dt(p_dt));
   always #25 aclk = ~aclk;
   task chk(input string what, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", what, e, s);
      end
   endtask : chk
   task give_verdict;
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      fork
         begin
            do @(posedge aclk); while (awready !== 1);
            awvalid <= 0;
         end
         begin
            do @(posedge aclk); while (wready !== 1);
            wvalid <= 0;
         end
      join
      do @(posedge aclk); while (bvalid !== 1);
      bready <= 0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
           input logic [1:0] rs = 0);
      expq.push_back({m, rs, e});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge aclk); while (arready !== 1);
      arvalid <= 0;
      do @(posedge aclk); while (rvalid !== 1);
      rready <= 0;
   endtask : rd
   // Checks each read answer against the oldest note.
   always @(posedge aclk) begin
      if (rvalid === 1 && rready === 1) begin
         chk("rresp", 32'(expq[0][33:32]), 32'(rresp));
         chk("rdata", expq[0][31:0], rdata & expq[0][65:34]);
         void'(expq.pop_front());
      end
   end
   initial begin
      #(30000 * 50);
      failures++;
      give_verdict();
   end
   initial begin
      void'($urandom(80425));
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      rd(`SSP_OFS_TXSTA, 32'h02); // Shifter empty.
      rd(`SSP_OFS_FLAGS, 32'h20); // Buffer empty.
      rd(8'h20, 0, '1, `SSP_RESP_SLV);
      wr(`SSP_OFS_DIVL, 8'h03); // Short divisor.
      wr(`SSP_OFS_TXSTA, 8'h90); // Master setup.
      wr(`SSP_OFS_RCSTA, 8'h80);
      wr(`SSP_OFS_FLAGS, 8'h01);
      w0 = 9'($urandom);
      wr(`SSP_OFS_RCSTA, 8'ha0); // Single word.
      peer.send(w0, 8);
      for (int i = 0; i < 20 && irq !== 1; i++) @(posedge aclk);
      chk("irq", 1, irq); // Request raised.
      rd(`SSP_OFS_RCSTA, 32'h80); // Enable cleared.
      rd(`SSP_OFS_RXBUF, 32'(w0[7:0])); // Low byte.
      rd(`SSP_OFS_FLAGS, 32'h21); // Flag cleared by read.
      wr(`SSP_OFS_BAUD, 8'h10);
      repeat (4) @(posedge aclk);
      chk("ck idle", 1, {ck_oe_n, ck_out}); // Idle high, driven.
      wr(`SSP_OFS_BAUD, 8'h00);
      w0 = 9'($urandom);
      w1 = 9'($urandom);
      wr(`SSP_OFS_RCSTA, 8'hf0); // Both set, nine bits.
      peer.send(w0, 9);
      peer.send(w1, 9); // Keeps going.
      repeat (4) @(posedge aclk);
      rd(`SSP_OFS_RCSTA, 32'(w0[8]) | 2, 32'h03); // Overrun, ninth.
      rd(`SSP_OFS_RXBUF, 32'(w0[7:0])); // Second word lost.
      wr(`SSP_OFS_RCSTA, 8'hc0);
      rd(`SSP_OFS_RCSTA, 0, 32'h02); // Overrun gone.
      w0 = 9'($urandom);
      w1 = 9'($urandom);
      // Ninth bit goes in before any load; both words carry it.
      wr(`SSP_OFS_TXSTA, 8'h70 | 8'(w0[8])); // Slave, nine bits.
      wr(`SSP_OFS_FLAGS, 8'h02);
      low_power <= 1;
      wr(`SSP_OFS_TXBUF, w0[7:0]);
      wr(`SSP_OFS_TXBUF, w1[7:0]);
      rd(`SSP_OFS_FLAGS, 0, 32'h20); // Second word waits.
      chk("wake", 0, wake); // No wake yet.
      peer.clock_in(9, got);
      chk("word 1", 32'(w0), 32'(got)); // Sent asleep.
      repeat (8) @(posedge aclk);
      chk("wake", 1, wake); // Wake on flag.
      rd(`SSP_OFS_FLAGS, 32'h20, 32'h20); // Flag on move.
      peer.clock_in(9, got);
      chk("word 2", 32'({w0[8], w1[7:0]}), 32'(got)); // Second follows.
      repeat (8) @(posedge aclk);
      rd(`SSP_OFS_TXSTA, 32'h72 | 32'(w0[8])); // Shifter empty again.
      give_verdict();
   end
endmodule : ssp_top_tb
